/* File: inc/scfn_pkg.sv */
// constants shared by the smart-card function configuration registers
// Overview of operation
// R01 - bridge support extension at 4Ah reads 00h
// R02 - power-management data at 4Bh reads zero
// R03 - bit 7 picks revision 010b or 011b
// R04 - bits 6-5 set interrupt pin and output
// R05 - asserted straps override the interrupt select field
// R06 - writing hide bit 4 hides the function
// R07 - config registers stay reachable while hidden
// R08 - hidden function gets PCI and 48 MHz gated
// R09 - control bits cleared by global reset only
// R10 - control bits 15-8 and 3-0 read zero
// R11 - control register also visible to socket registers
// R12 - alias bits 31-16 appear at 2Eh
// R13 - alias bits 15-0 appear at 2Ch
// R14 - alias: global reset, host write, EEPROM load
// R15 - class mirror at 54h writable and loadable
// R16 - class mirror resets to 0780_0000h
// R17 - capability revision bits 2-0 follow bit 7
// R18 - writes to read-only bits change nothing
package scfn_pkg;
    // configuration dword addresses
    localparam logic [7:0] OFF_CLASS        = 8'h08; // class code dword
    localparam logic [7:0] OFF_SUBSYS       = 8'h2c; // maker code 2Ch, device code 2Eh
    localparam logic [7:0] OFF_INTERRUPT_PIN_REGISTER       = 8'h3c; // pin register sits in byte 3Dh
    localparam logic [7:0] OFF_PM_CAP       = 8'h44; // capabilities word at 46h
    localparam logic [7:0] OFF_PM_CSR       = 8'h48; // holds 4Ah and 4Bh bytes
    localparam logic [7:0] OFF_PM_BSE       = 8'h4a; // bridge support extension byte
    localparam logic [7:0] OFF_PM_DATA      = 8'h4b; // power-management data byte
    localparam logic [7:0] OFF_GEN_CTRL     = 8'h4c; // general control
    localparam logic [7:0] OFF_ID_ALIAS     = 8'h50; // subsystem identity alias
    localparam logic [7:0] OFF_CLASS_MIRROR = 8'h54; // class code mirror
    // field positions
    localparam int GC_REV_BIT     = 7;  // revision select
    localparam int GC_INTSEL_LSB  = 5;  // interrupt select, two bits
    localparam int GC_HIDE_BIT    = 4;  // function hide
    localparam int PM_REV_LSB     = 16; // revision field inside 44h dword
    localparam int INTERRUPT_PIN_REGISTER_LSB     = 8;  // pin register inside 3Ch dword
    localparam int BSE_LSB        = 16; // 4Ah byte inside 48h dword
    localparam int PMDATA_LSB     = 24; // 4Bh byte inside 48h dword
    localparam int HALF_LSB       = 16; // device code half of 2Ch dword
    // values
    localparam logic [2:0]  PM_REV_V11   = 3'h2;         // revision 1.1
    localparam logic [2:0]  PM_REV_V12   = 3'h3;         // revision 1.2
    localparam logic [7:0]  PM_ZERO_BYTE = 8'h00;        // 4Ah and 4Bh value
    localparam logic [15:0] GC_RESET     = 16'h0000;     // general control default
    localparam logic [15:0] GC_RW_MASK   = 16'h00f0;     // writable control bits
    localparam logic [31:0] CLASS_RESET  = 32'h0780_0000; // class mirror default
    localparam logic [7:0]  PIN_INTA     = 8'h01;        // pin value of line A
    localparam int          NUM_LINES    = 4;            // interrupt lines A to D
endpackage

/* File: inc/scfn_intr_if.sv */
// interrupt routing signals between strap sync, pin mapper and register bank
`timescale 1ns/1ps
interface scfn_intr_if;
    logic [3:0] strap_level;  // filtered strap levels, one per line
    logic [1:0] sel_field;    // interrupt select field from control
    logic [7:0] pin_value;    // interrupt pin register value
    logic [3:0] route;        // one-hot chosen interrupt line
    logic       strap_active; // some strap is asserted
    modport sync (output strap_level);
    modport map  (input strap_level, input sel_field,
                  output pin_value, output route, output strap_active);
    modport ctl  (output sel_field, input pin_value, input route, input strap_active);
endinterface

/* File: verilog/scfn_strap_sync.sv */
// three-stage synchroniser and filter for the strap terminals
`timescale 1ns/1ps
module scfn_strap_sync #(
    parameter int WIDTH = 4  // number of strap terminals
) (
    input  wire logic   clk_sys,   // system clock
    input  wire logic   rst_n,     // asynchronous reset, active low
    input  wire logic [WIDTH-1:0] strap_pins, // raw strap levels
    scfn_intr_if.sync   intr       // filtered levels out
);
    genvar g;
    // one synchroniser per terminal
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta;   // first stage, read only by second
            logic st2;    // second stage
            logic st3;    // third stage
            logic level;  // accepted level
            // shift chain; first stage feeds nothing but the second
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= 1'b0;
                    st2  <= 1'b0;
                    st3  <= 1'b0;
                end else begin
                    meta <= strap_pins[g];
                    st2  <= meta;
                    st3  <= st2;
                end
            end
            // a change counts only once stages two and three agree
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    level <= 1'b0;
                end else if (st2 == st3) begin
                    level <= st3;
                end
            end
            assign intr.strap_level[g] = level;
        end
    endgenerate
endmodule

/* File: verilog/scfn_interrupt_pin_register_map.sv */
// maps select field or straps to pin value and one-hot routing
`timescale 1ns/1ps
module scfn_interrupt_pin_register_map (
    input  wire logic clk_sys, // system clock
    input  wire logic rst_n,   // asynchronous reset, active low
    scfn_intr_if.map  intr     // routing signals
);
    // line index to pin value, A is 1
    function automatic logic [7:0] pin_of(input logic [1:0] idx);
        pin_of = scfn_pkg::PIN_INTA + {6'h00, idx};
    endfunction
    logic [1:0] next_idx; // chosen line
    logic       any;      // some strap asserted
    // R05 strap wins over select: lowest asserted strap picks the line
    always_comb begin
        any      = |intr.strap_level;
        next_idx = intr.sel_field;
        if (intr.strap_level[0]) next_idx = 2'h0;
        else if (intr.strap_level[1]) next_idx = 2'h1;
        else if (intr.strap_level[2]) next_idx = 2'h2;
        else if (intr.strap_level[3]) next_idx = 2'h3;
    end
    // R04 registered pin value and routing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intr.pin_value    <= scfn_pkg::PIN_INTA;
            intr.route        <= 4'h1;
            intr.strap_active <= 1'b0;
        end else begin
            intr.pin_value    <= pin_of(next_idx);
            intr.route        <= 4'h1 << next_idx;
            intr.strap_active <= any;
        end
    end
endmodule

/* File: verilog/scfn_cfg_regs.sv */
// configuration registers of the smart-card function
`timescale 1ns/1ps
module scfn_cfg_regs #(
    parameter logic [31:0] SUBSYS_RESET = 32'h1234_5678 // arbitrary identity default
) (
    input  wire logic        clk_sys,         // system (PCI) clock
    input  wire logic        rst_n,           // global reset, async, active low
    input  wire logic        cfg_rd,          // config read request, pulse
    input  wire logic        cfg_wr,          // config write request, pulse
    input  wire logic [7:0]  cfg_addr,        // config byte address
    input  wire logic [3:0]  cfg_be,          // byte enables, active high
    input  wire logic [31:0] cfg_wdata,       // write data
    output logic      [31:0] cfg_rdata,       // read data, registered
    output logic             cfg_ack,         // request done, pulse
    input  wire logic        ee_load,         // eeprom load strobe, pulse
    input  wire logic [7:0]  ee_addr,         // eeprom target address
    input  wire logic [31:0] ee_data,         // eeprom dword
    input  wire logic [3:0]  interrupt_strap_terminals, // strap pins A..D
    input  wire logic        func_irq,        // function interrupt request
    output logic      [3:0]  intx_o,          // interrupt pin output values
    output logic      [3:0]  intx_oe,         // interrupt pin drive enables
    output logic             func_hidden,     // function hidden from system
    output logic             func_pci_clk_en, // clock gate enable, PCI
    output logic             func_48m_clk_en, // clock gate enable, 48 MHz
    output logic      [15:0] gen_ctrl_view,   // copy for socket register set
    output logic      [2:0]  pm_revision_field // reported pm revision
);
    // dword index compare
    function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
        hits = (a[7:2] == off[7:2]);
    endfunction

    // byte-enable merge
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = be[i] ? 8'hff : 8'h00;
        end
        merge = (new_v & m) | (old_v & ~m);
    endfunction

    scfn_intr_if intr (); // routing bundle

    // strap terminals come from pins
    scfn_strap_sync #(
        .WIDTH      (scfn_pkg::NUM_LINES)
    ) u_sync (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .strap_pins (interrupt_strap_terminals),
        .intr       (intr.sync)
    );

    // pin value and line choice
    scfn_interrupt_pin_register_map u_map (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .intr    (intr.map)
    );

    // control register state
    logic        pm_revision_select; // revision control bit
    logic [1:0]  int_sel;            // interrupt select field
    logic        function_hide;      // hide bit
    logic [31:0] subsys_alias;       // identity alias word
    logic [31:0] class_code_mirror;  // class code mirror word
    logic [15:0] gc_word;            // assembled control register
    logic [31:0] id_word;            // assembled alias word
    logic        host_gc;            // host writes control
    logic        host_id;            // host writes alias
    logic        host_cc;            // host writes class mirror
    logic        ee_gc;              // eeprom loads control
    logic        ee_id;              // eeprom loads alias
    logic        ee_cc;              // eeprom loads class mirror
    logic [31:0] gc_new;             // control data after merge
    logic [31:0] next_rdata;         // read mux result

    assign intr.sel_field = int_sel;
    assign id_word        = subsys_alias;

    // write strobes; the eeprom loader carries whole dwords
    always_comb begin
        host_gc = cfg_wr && hits(cfg_addr, scfn_pkg::OFF_GEN_CTRL);
        host_id = cfg_wr && hits(cfg_addr, scfn_pkg::OFF_ID_ALIAS);
        host_cc = cfg_wr && hits(cfg_addr, scfn_pkg::OFF_CLASS_MIRROR);
        ee_gc   = ee_load && hits(ee_addr, scfn_pkg::OFF_GEN_CTRL);
        ee_id   = ee_load && hits(ee_addr, scfn_pkg::OFF_ID_ALIAS);
        ee_cc   = ee_load && hits(ee_addr, scfn_pkg::OFF_CLASS_MIRROR);
    end

    // R10 reserved control bits are assembled as zero
    always_comb begin
        gc_word = scfn_pkg::GC_RESET;
        gc_word[scfn_pkg::GC_REV_BIT] = pm_revision_select;
        gc_word[scfn_pkg::GC_INTSEL_LSB +: 2] = int_sel;
        gc_word[scfn_pkg::GC_HIDE_BIT] = function_hide;
    end

    // merged value for a control write; eeprom load takes priority
    always_comb begin
        if (ee_gc) begin
            gc_new = ee_data;
        end else begin
            gc_new = merge({16'h0000, gc_word}, cfg_wdata, cfg_be);
        end
    end

    // R09 control bits cleared only by the global reset
    // R06 hide bit, revision select and select field take writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pm_revision_select <= scfn_pkg::GC_RESET[scfn_pkg::GC_REV_BIT];
            int_sel            <= scfn_pkg::GC_RESET[scfn_pkg::GC_INTSEL_LSB +: 2];
            function_hide      <= scfn_pkg::GC_RESET[scfn_pkg::GC_HIDE_BIT];
        end else if (ee_gc || host_gc) begin
            // R18 reserved bits of the written word are dropped
            pm_revision_select <= gc_new[scfn_pkg::GC_REV_BIT];
            int_sel            <= gc_new[scfn_pkg::GC_INTSEL_LSB +: 2];
            function_hide      <= gc_new[scfn_pkg::GC_HIDE_BIT];
        end
    end

    // R14 identity alias: global reset, host write or eeprom load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            subsys_alias <= SUBSYS_RESET;
        end else if (ee_id) begin
            subsys_alias <= ee_data;
        end else if (host_id) begin
            subsys_alias <= merge(subsys_alias, cfg_wdata, cfg_be);
        end
    end

    // R16 mirror default after global reset
    // R15 mirror is writable and eeprom loadable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            class_code_mirror <= scfn_pkg::CLASS_RESET;
        end else if (ee_cc) begin
            class_code_mirror <= ee_data;
        end else if (host_cc) begin
            class_code_mirror <= merge(class_code_mirror, cfg_wdata, cfg_be);
        end
    end

    // read decode; unmapped dwords return zero
    // R07 no dependence on the hide bit: config space always answers
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hits(cfg_addr, scfn_pkg::OFF_CLASS)) begin
            // R15 original class code reads through the mirror
            next_rdata = class_code_mirror;
        end else if (hits(cfg_addr, scfn_pkg::OFF_SUBSYS)) begin
            // R13 vendor half from alias bits 15-0
            next_rdata[0 +: scfn_pkg::HALF_LSB] = id_word[0 +: scfn_pkg::HALF_LSB];
            // R12 device half from alias bits 31-16
            next_rdata[scfn_pkg::HALF_LSB +: 16] = id_word[scfn_pkg::HALF_LSB +: 16];
        end else if (hits(cfg_addr, scfn_pkg::OFF_INTERRUPT_PIN_REGISTER)) begin
            // R04 pin register shows the chosen line
            next_rdata[scfn_pkg::INTERRUPT_PIN_REGISTER_LSB +: 8] = intr.pin_value;
        end else if (hits(cfg_addr, scfn_pkg::OFF_PM_CAP)) begin
            // R17 capability revision follows revision select
            next_rdata[scfn_pkg::PM_REV_LSB +: 3] = pm_revision_field;
        end else if (hits(cfg_addr, scfn_pkg::OFF_PM_CSR)) begin
            // R01 bridge support extension byte is fixed
            next_rdata[scfn_pkg::BSE_LSB +: 8] = scfn_pkg::PM_ZERO_BYTE;
            // R02 power-management data byte is fixed
            next_rdata[scfn_pkg::PMDATA_LSB +: 8] = scfn_pkg::PM_ZERO_BYTE;
        end else if (hits(cfg_addr, scfn_pkg::OFF_GEN_CTRL)) begin
            // R10 upper half and reserved bits read zero
            next_rdata[15:0] = gc_word;
        end else if (hits(cfg_addr, scfn_pkg::OFF_ID_ALIAS)) begin
            next_rdata = id_word;
        end else if (hits(cfg_addr, scfn_pkg::OFF_CLASS_MIRROR)) begin
            next_rdata = class_code_mirror;
        end
    end

    // one-cycle answer to every request, read data held until next read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack   <= 1'b0;
        end else begin
            // R18 writes anywhere are acknowledged without error
            cfg_ack <= cfg_rd || cfg_wr;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // R03 revision field from revision select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pm_revision_field <= scfn_pkg::PM_REV_V11;
        end else if (pm_revision_select) begin
            pm_revision_field <= scfn_pkg::PM_REV_V12;
        end else begin
            pm_revision_field <= scfn_pkg::PM_REV_V11;
        end
    end

    // R11 copy of the control register for the socket register set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gen_ctrl_view <= scfn_pkg::GC_RESET;
        end else begin
            gen_ctrl_view <= gc_word;
        end
    end

    // R08 hidden function loses both clock enables
    // registered so the gate cells never see a glitching enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            func_hidden     <= 1'b0;
            func_pci_clk_en <= 1'b1;
            func_48m_clk_en <= 1'b1;
        end else begin
            func_hidden     <= function_hide;
            func_pci_clk_en <= !function_hide;
            func_48m_clk_en <= !function_hide;
        end
    end

    // interrupt lines are open drain: pull low on the routed line only
    // a hidden function raises no interrupt: its request is masked by the hide bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intx_o  <= 4'h0;
            intx_oe <= 4'h0;
        end else begin
            intx_o <= 4'h0;
            // R04 request goes out on the selected line
            if (func_irq && !function_hide) begin
                intx_oe <= intr.route;
            end else begin
                intx_oe <= 4'h0;
            end
        end
    end
endmodule

/* File: tb/scfn_cfg_host.sv */
// host model issuing configuration cycles
`timescale 1ns/1ps
module scfn_cfg_host (
    input  wire logic        clk_sys,   // system clock
    output logic             cfg_rd,    // read request pulse
    output logic             cfg_wr,    // write request pulse
    output logic      [7:0]  cfg_addr,  // byte address
    output logic      [3:0]  cfg_be,    // byte enables
    output logic      [31:0] cfg_wdata  // write data
);
    int slow = 0; // idle cycles before a request
    // idle bus at time zero
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    // one-cycle request; rd and wr dropped, address, enables and data inverted once released
    task automatic req(input logic rd, input logic wr, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        repeat (slow) @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        cfg_rd = rd;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk_sys);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_be = ~be;
        cfg_wdata = ~d;
    endtask
endmodule

/* File: tb/scfn_cfg_regs_assertions.sv */
// concurrent checks on the register block's ports
`timescale 1ns/1ps
module scfn_cfg_regs_assertions (
    input wire logic        clk_sys,           // clock
    input wire logic        rst_n,             // global reset
    input wire logic        cfg_rd,            // read request
    input wire logic        cfg_wr,            // write request
    input wire logic [7:0]  cfg_addr,          // address
    input wire logic [3:0]  cfg_be,            // byte enables
    input wire logic [31:0] cfg_wdata,         // write data
    input wire logic [31:0] cfg_rdata,         // read data
    input wire logic        cfg_ack,           // done pulse
    input wire logic        ee_load,           // eeprom strobe
    input wire logic [3:0]  intx_o,            // pin values
    input wire logic [3:0]  intx_oe,           // pin enables
    input wire logic        func_hidden,       // hidden flag
    input wire logic        func_pci_clk_en,   // pci gate
    input wire logic        func_48m_clk_en,   // 48 MHz gate
    input wire logic [15:0] gen_ctrl_view,     // control copy
    input wire logic [2:0]  pm_revision_field  // revision
);
    logic [3:0] wr_nib; // control nibble of a write
    assign wr_nib = cfg_wdata[7:4];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // any request taken at this edge
    sequence s_req;
        cfg_rd || cfg_wr;
    endsequence
    // host write to the control byte
    sequence s_ctrl_wr;
        cfg_wr && cfg_addr[7:2] == 6'h13 && cfg_be[0] && !ee_load;
    endsequence
    AST_ACK_PULSE: assert property (s_req |=> cfg_ack)
        else $error("ack missing");
    AST_ACK_IDLE: assert property (!(cfg_rd || cfg_wr) |=> !cfg_ack)
        else $error("stray ack");
    AST_RDATA_HOLD: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved");
    AST_PM_ZERO: assert property (cfg_rd && cfg_addr[7:2] == 6'h12 |=> cfg_rdata == 32'h0)
        else $error("pm bytes not zero");
    AST_REV_TRACK: assert property (pm_revision_field == {2'b01, gen_ctrl_view[7]})
        else $error("revision mismatch");
    AST_RSVD_ZERO: assert property (gen_ctrl_view[15:8] == 8'h00 && gen_ctrl_view[3:0] == 4'h0)
        else $error("reserved bits set");
    AST_GATE: assert property (func_pci_clk_en == !func_hidden && func_48m_clk_en == !func_hidden)
        else $error("gates disagree with hide");
    AST_HIDE_VIEW: assert property (func_hidden == gen_ctrl_view[4])
        else $error("hidden flag wrong");
    AST_CTRL_WR: assert property (s_ctrl_wr |-> ##2 gen_ctrl_view[7:4] == $past(wr_nib, 2))
        else $error("control write lost");
    AST_IRQ_HIDDEN: assert property (func_hidden [*2] |-> intx_oe == 4'h0)
        else $error("irq while hidden");
    AST_INTX_ONEHOT: assert property ($onehot0(intx_oe) && intx_o == 4'h0)
        else $error("lines not one-hot low");
    AST_RESET_CTRL: assert property ($rose(rst_n) |-> gen_ctrl_view == 16'h0 && !cfg_ack)
        else $error("control not reset");
endmodule
bind scfn_cfg_regs scfn_cfg_regs_assertions u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .ee_load(ee_load), .intx_o(intx_o), .intx_oe(intx_oe),
    .func_hidden(func_hidden), .func_pci_clk_en(func_pci_clk_en),
    .func_48m_clk_en(func_48m_clk_en), .gen_ctrl_view(gen_ctrl_view),
    .pm_revision_field(pm_revision_field));

/* File: tb/tb.sv */
// self-checking bench for the configuration registers
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] ID_DEF = 32'h0bad_c0de; // arbitrary value
    logic        clk_sys, rst_n, cfg_rd, cfg_wr, cfg_ack, ee_load, func_irq;
    logic        func_hidden, func_pci_clk_en, func_48m_clk_en;
    logic [7:0]  cfg_addr, ee_addr;
    logic [3:0]  cfg_be, straps, intx_o, intx_oe;
    logic [31:0] cfg_wdata, cfg_rdata, ee_data, r;
    logic [15:0] gen_ctrl_view;
    logic [2:0]  pm_revision_field;
    logic [32:0] mon_e;      // bit 32 marks a read
    logic [32:0] exp_q[$];   // notes in issue order
    int          errors = 0;
    int          n_compared = 0;

    scfn_cfg_regs #(.SUBSYS_RESET(ID_DEF)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .ee_load(ee_load),
        .ee_addr(ee_addr), .ee_data(ee_data), .interrupt_strap_terminals(straps),
        .func_irq(func_irq), .intx_o(intx_o), .intx_oe(intx_oe),
        .func_hidden(func_hidden), .func_pci_clk_en(func_pci_clk_en),
        .func_48m_clk_en(func_48m_clk_en), .gen_ctrl_view(gen_ctrl_view),
        .pm_revision_field(pm_revision_field));
    scfn_cfg_host host (
        .clk_sys(clk_sys), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // read data compare
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    // output level compare
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // random pacing, prompt or slow
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({1'b1, e});
        host.slow = $urandom_range(0, 2);
        host.req(1'b1, 1'b0, a, 4'hf, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        exp_q.push_back({1'b0, 32'h0000_0000});
        host.slow = $urandom_range(0, 2);
        host.req(1'b0, 1'b1, a, be, d);
    endtask
    // eeprom preload of one dword
    task automatic ee(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        ee_load = 1'b1;
        ee_addr = a;
        ee_data = d;
        cyc(1);
        ee_load = 1'b0;
        ee_addr = ~a;
        ee_data = ~d;
    endtask
    // each ack retires the oldest note; mid-cycle, away from the launching edge
    always @(negedge clk_sys) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("mismatch at %0t: stray ack", $time);
            end else begin
                mon_e = exp_q.pop_front();
                if (mon_e[32]) chk_rd(cfg_rdata, mon_e[31:0]);
            end
        end
    end
    task automatic finish_test();
        if (exp_q.size() != 0) errors++;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog, far past the run length
    initial begin
        #200_000;
        errors++;
        $display("mismatch at %0t: timeout", $time);
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        ee_load = 1'b0;
        ee_addr = 8'h00;
        ee_data = 32'h0000_0000;
        straps = 4'h0;
        func_irq = 1'b1;
        r = $urandom(22);
        cyc(10);
        rst_n = 1'b1;
        rd(8'h4c, 32'h0000_0000);
        rd(8'h54, 32'h0780_0000);
        rd(8'h48, 32'h0000_0000);
        rd(8'h44, 32'h0002_0000);
        rd(8'h2c, ID_DEF);
        rd(8'h60, 32'h0000_0000);
        // all ones: four control bits stick, function hidden
        wr(8'h4c, 4'hf, 32'hffff_ffff);
        rd(8'h4c, 32'h0000_00f0);
        rd(8'h44, 32'h0003_0000);
        rd(8'h08, 32'h0780_0000);
        cyc(2);
        chk_out(32'(func_hidden), 32'h1);
        chk_out(32'(func_pci_clk_en), 32'h0);
        chk_out(32'(func_48m_clk_en), 32'h0);
        chk_out(32'(gen_ctrl_view), 32'h0000_00f0);
        chk_out(32'(intx_oe), 32'h0);
        // each select code, function visible
        for (int s = 0; s < 4; s++) begin
            wr(8'h4c, 4'h1, 32'(s) << 5);
            rd(8'h3c, 32'(s + 1) << 8);
            cyc(2);
            chk_out(32'(intx_oe), 32'h1 << s);
        end
        chk_out(32'(pm_revision_field), 32'h2);
        chk_out(32'(func_48m_clk_en), 32'h1);
        // straps win, lowest line first
        for (int k = 0; k < 3; k++) begin
            straps = 4'($urandom_range(1, 15));
            cyc(8);
            chk_out(32'(intx_oe), 32'(straps & (~straps + 4'h1)));
        end
        straps = 4'h2;
        cyc(8);
        rd(8'h3c, 32'h0000_0200);
        straps = 4'h0;
        cyc(8);
        chk_out(32'(intx_oe), 32'h8);
        func_irq = 1'b0;
        // alias by host, by lanes, by eeprom; then class mirror, control load and 48h write
        r = $urandom();
        wr(8'h50, 4'hf, r);
        rd(8'h2c, r);
        wr(8'h50, 4'b0101, ~r);
        rd(8'h50, {r[31:24], ~r[23:16], r[15:8], ~r[7:0]});
        ee(8'h50, r ^ 32'h5a5a_5a5a);
        rd(8'h2c, r ^ 32'h5a5a_5a5a);
        ee(8'h54, r);
        rd(8'h08, r);
        wr(8'h54, 4'hf, ~r);
        rd(8'h54, ~r);
        ee(8'h4c, 32'h0000_0080);
        cyc(2);
        chk_out(32'(pm_revision_field), 32'h3);
        chk_out(32'(intx_oe), 32'h0);
        wr(8'h48, 4'hf, 32'hffff_ffff);
        rd(8'h48, 32'h0000_0000);
        // mid-run reset restores defaults
        cyc(2);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        rd(8'h4c, 32'h0000_0000);
        rd(8'h54, 32'h0780_0000);
        rd(8'h50, ID_DEF);
        cyc(4);
        finish_test();
    end
endmodule
